/* File: logic/oscillator_select_control.sv */
`timescale 1ns/1ns
`include "osc_ctrl_params.svh"

module oscillator_select_control (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       src_sel_pin_i,
  input  wire logic [7:0] periph_num_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  output logic            src_sel_o,
  output logic            int_osc_en_o,
  output logic            int_osc_slow_o,
  output logic            xtal_en_o,
  output logic            xtal_bias_en_o,
  output logic            tile_rst_o
);

  osc_ctrl_pkg::osc_state_t s_q;
  osc_ctrl_pkg::osc_state_t s_d;
  logic                     sel_hit;
  logic                     new_sel;

  // Accesses are byte wide; only peripheral 4 answers.
  assign sel_hit = (periph_num_i == `OSC_PERIPH_NUM);

  always_comb begin
    s_d          = s_q;
    new_sel      = s_q.src_sel_q;
    s_d.strap_q  = {s_q.strap_q[0], src_sel_pin_i};
    s_d.rvalid_q = 1'h0;
    // The count stops once both synchroniser stages hold a sampled pin value.
    if (s_q.strap_cnt_q != `OSC_STRAP_SYNC_CYC) begin
      s_d.strap_cnt_q = s_q.strap_cnt_q + 2'h1;
    end
    // The strap is taken once after the synchroniser has settled, never under reset.
    // Taking it any earlier would latch the reset zero of the flops instead of the pin.
    if (!s_q.strap_done_q) begin
      if (s_q.strap_cnt_q == `OSC_STRAP_SYNC_CYC) begin
        s_d.strap_done_q = 1'h1;
        s_d.src_sel_q    = s_q.strap_q[1];
      end
    end else if (sel_hit && wr_i) begin
      unique case (addr_i)
        `OSC_GEN_OFFSET: begin
          new_sel         = wdata_i[`OSC_SEL_BIT];
          s_d.src_sel_q   = new_sel;
          s_d.rst_on_sw_q = wdata_i[`OSC_RST_EN_BIT];
        end
        `OSC_INT_OFFSET: begin
          s_d.int_en_q   = wdata_i[`OSC_EN_BIT];
          s_d.int_slow_q = wdata_i[`OSC_SPEED_BIT];
        end
        `OSC_XTAL_OFFSET: begin
          s_d.xtal_en_q   = wdata_i[`OSC_EN_BIT];
          s_d.xtal_bias_q = wdata_i[`OSC_BIAS_BIT];
        end
        default: begin
        end
      endcase
    end
    // A tile reset stretches a few cycles so the tile sees a clean pulse.
    if (s_q.strap_done_q && sel_hit && wr_i && addr_i == `OSC_GEN_OFFSET
        && s_q.rst_on_sw_q && new_sel != s_q.src_sel_q) begin
      s_d.tile_rst_cnt_q = `OSC_TILE_RST_CYC;
    end else if (s_q.tile_rst_cnt_q != 4'h0) begin
      s_d.tile_rst_cnt_q = s_q.tile_rst_cnt_q - 4'h1;
    end
    s_d.tile_rst_q = (s_d.tile_rst_cnt_q != 4'h0);
    if (sel_hit && rd_i) begin
      s_d.rvalid_q = 1'h1;
      unique case (addr_i)
        `OSC_GEN_OFFSET:  s_d.rdata_q = {6'h00, s_q.rst_on_sw_q, s_q.src_sel_q};
        `OSC_INT_OFFSET:  s_d.rdata_q = {6'h00, s_q.int_slow_q, s_q.int_en_q};
        `OSC_XTAL_OFFSET: s_d.rdata_q = {6'h00, s_q.xtal_bias_q, s_q.xtal_en_q};
        default:          s_d.rdata_q = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q                <= '0;
      s_q.rst_on_sw_q    <= `OSC_RST_EN_RESET;
      s_q.int_en_q       <= `OSC_INT_EN_RESET;
      s_q.int_slow_q     <= `OSC_SPEED_RESET;
      s_q.xtal_en_q      <= `OSC_XTAL_EN_RESET;
      s_q.xtal_bias_q    <= `OSC_BIAS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o        = s_q.rdata_q;
  assign rvalid_o       = s_q.rvalid_q;
  assign src_sel_o      = s_q.src_sel_q;
  assign int_osc_en_o   = s_q.int_en_q;
  assign int_osc_slow_o = s_q.int_slow_q;
  assign xtal_en_o      = s_q.xtal_en_q;
  assign xtal_bias_en_o = s_q.xtal_bias_q;
  assign tile_rst_o     = s_q.tile_rst_q;

  // Write checks wait for the strap, since writes in the first cycles after reset are dropped.
  a_sel_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.strap_done_q && sel_hit && wr_i && addr_i == 8'h00 |=> src_sel_o == $past(wdata_i[0]))
    else $error("source select did not follow write");

  a_tile_rst_on: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $changed(src_sel_o) && $past(s_q.rst_on_sw_q) && $past(s_q.strap_done_q) |-> tile_rst_o [*4])
    else $error("tile reset missing on source change");

  a_tile_rst_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(tile_rst_o) |-> $past(s_q.rst_on_sw_q))
    else $error("tile reset without enable");

  a_rst_needs_change: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(tile_rst_o) |-> $changed(src_sel_o))
    else $error("tile reset without a source change");

  a_speed_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.strap_done_q && sel_hit && wr_i && addr_i == 8'h01 |=> int_osc_slow_o == $past(wdata_i[1]))
    else $error("speed bit did not follow write");

  a_int_en_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.strap_done_q && sel_hit && wr_i && addr_i == 8'h01 |=> int_osc_en_o == $past(wdata_i[0]))
    else $error("internal enable did not follow write");

  a_bias_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.strap_done_q && sel_hit && wr_i && addr_i == 8'h02 |=> xtal_bias_en_o == $past(wdata_i[1]))
    else $error("bias bit did not follow write");

  a_xtal_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.strap_done_q && sel_hit && wr_i && addr_i == 8'h02 |=> xtal_en_o == $past(wdata_i[0]))
    else $error("crystal enable did not follow write");

  a_rsvd_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rvalid_o |-> rdata_o[7:2] == 6'h00)
    else $error("reserved bits read nonzero");

  a_unmapped_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_hit && rd_i && addr_i > 8'h02 |=> rdata_o == 8'h00)
    else $error("unmapped offset read nonzero");

  a_other_periph: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !sel_hit |=> !rvalid_o)
    else $error("answered another peripheral");

  a_read_answer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_hit && rd_i |=> rvalid_o)
    else $error("read to this peripheral got no answer");

  a_answer_cause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rvalid_o |-> $past(sel_hit) && $past(rd_i))
    else $error("read answer without a read");

  a_foreign_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.strap_done_q && !sel_hit |=> $stable(src_sel_o) && $stable(int_osc_en_o) && $stable(int_osc_slow_o)
      && $stable(xtal_en_o) && $stable(xtal_bias_en_o))
    else $error("another peripheral changed a control output");

  a_gen_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_hit && rd_i && addr_i == 8'h00 |=> rdata_o[0] == $past(src_sel_o))
    else $error("source select read back wrong");

  a_int_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_hit && rd_i && addr_i == 8'h01 |=> rdata_o[1] == $past(int_osc_slow_o) && rdata_o[0] == $past(int_osc_en_o))
    else $error("internal oscillator register read back wrong");

  a_xtal_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_hit && rd_i && addr_i == 8'h02 |=> rdata_o[1] == $past(xtal_bias_en_o) && rdata_o[0] == $past(xtal_en_o))
    else $error("crystal register read back wrong");

  // The strap must be the synchronised pin, not the reset value of the flops.
  a_strap_capture: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(s_q.strap_done_q) |-> src_sel_o == $past(s_q.strap_q[1]))
    else $error("source select did not take the strap");

  a_early_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !s_q.strap_done_q |=> $stable(int_osc_en_o) && $stable(int_osc_slow_o) && $stable(xtal_en_o)
      && $stable(xtal_bias_en_o))
    else $error("write landed before strap capture");

  // Reset values are checked at the first edge after release, before any write can land.
  a_int_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> int_osc_en_o)
    else $error("internal enable not set after reset");

  a_speed_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !int_osc_slow_o)
    else $error("slow speed selected after reset");

  a_xtal_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> xtal_en_o)
    else $error("crystal enable not set after reset");

  a_bias_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> xtal_bias_en_o)
    else $error("bias enable not set after reset");

  a_rst_en_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !s_q.rst_on_sw_q && !tile_rst_o)
    else $error("tile reset enable set after reset");

  c_switch_rst: cover property (@(posedge mclk_i) $rose(tile_rst_o));
  c_slow: cover property (@(posedge mclk_i) $rose(int_osc_slow_o));
  c_xtal_off: cover property (@(posedge mclk_i) $fell(xtal_en_o));
  c_int_off: cover property (@(posedge mclk_i) $fell(int_osc_en_o));
  c_strap_take: cover property (@(posedge mclk_i) $rose(s_q.strap_done_q));

endmodule

/* File: logic/osc_ctrl_params.svh */
`ifndef OSC_CTRL_PARAMS_SVH
`define OSC_CTRL_PARAMS_SVH

`define OSC_PERIPH_NUM     8'h04
`define OSC_GEN_OFFSET     8'h00
`define OSC_INT_OFFSET     8'h01
`define OSC_XTAL_OFFSET    8'h02
`define OSC_SEL_BIT        0
`define OSC_RST_EN_BIT     1
`define OSC_EN_BIT         0
`define OSC_SPEED_BIT      1
`define OSC_BIAS_BIT       1
`define OSC_RST_EN_RESET   1'h0
`define OSC_INT_EN_RESET   1'h1
`define OSC_SPEED_RESET    1'h0
`define OSC_XTAL_EN_RESET  1'h1
`define OSC_BIAS_RESET     1'h1
`define OSC_TILE_RST_CYC   4'h4
`define OSC_STRAP_SYNC_CYC 2'h2

`endif

/* File: logic/osc_ctrl_pkg.sv */
package osc_ctrl_pkg;
  typedef struct packed {
    logic [1:0] strap_q;
    logic [1:0] strap_cnt_q;
    logic       strap_done_q;
    logic       src_sel_q;
    logic       rst_on_sw_q;
    logic       int_en_q;
    logic       int_slow_q;
    logic       xtal_en_q;
    logic       xtal_bias_q;
    logic [3:0] tile_rst_cnt_q;
    logic       tile_rst_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
  } osc_state_t;
endpackage

/* File: verif/osc_board_model.sv */
`timescale 1ns/1ns
module osc_board_model #(
  parameter logic STRAP = 1'b1
) (
  input  wire logic xtal_en_i,
  output logic      strap_o,
  output logic      osc_clk_o
);
  // A packaged oscillator needs no bias, so the bias enable is left unwatched here.
  assign strap_o = STRAP;
  initial osc_clk_o = 1'b0;
  // The clock stands still while the enable is low or still unknown at power-up.
  always #13 osc_clk_o = (xtal_en_i === 1'b1) ? ~osc_clk_o : 1'b0;
endmodule

/* File: verif/oscillator_select_control_bench.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module oscillator_select_control_bench;
  logic       mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, strap, xclk;
  logic [7:0] periph_num_i = 8'h04, addr_i = 8'h00, wdata_i = 8'h00, rdata_o, p;
  logic       rvalid_o, src_sel_o, int_osc_en_o, int_osc_slow_o, xtal_en_o, xtal_bias_en_o, tile_rst_o;
  logic [7:0] exp_q[$];
  int         n_mismatch = 0, n_tests = 0, cyc = 0, seed = 98675, k, run = 0, n_xedge = 0, lv;
  int         len_q[$];
  logic [7:0] ev;
  always #10 mclk_i = ~mclk_i;
  osc_board_model #(.STRAP(1'b1)) board (.xtal_en_i(xtal_en_o), .strap_o(strap), .osc_clk_o(xclk));
  oscillator_select_control uut (.mclk_i, .rst_n_i, .src_sel_pin_i(strap), .periph_num_i, .addr_i, .wr_i, .rd_i,
    .wdata_i, .rdata_o, .rvalid_o, .src_sel_o, .int_osc_en_o, .int_osc_slow_o, .xtal_en_o, .xtal_bias_en_o,
    .tile_rst_o);
  always @(posedge xclk) n_xedge++;
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One access and one idle cycle, so the next call never reassigns a strobe in the same time step.
  task acc(input logic [7:0] pn, a, d, input logic w);
    periph_num_i = pn;
    addr_i = a;
    wdata_i = d;
    wr_i = w;
    rd_i = ~w;
    @(posedge mclk_i);
    #2 wr_i = 0;
    rd_i = 0;
    @(posedge mclk_i);
    #2;
  endtask
  task rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    acc(8'h04, a, 8'h00, 1'b0);
  endtask
  // A read answer with nothing expected means a foreign access was answered.
  always @(negedge mclk_i) if (rvalid_o === 1'b1) begin
    if (exp_q.size() == 0) `CHK("rvalid", 1'b0, 1'b1)
    else begin
      ev = exp_q.pop_front();
      `CHK("rdata", ev, rdata_o)
    end
  end
  // Each tile reset pulse is measured when it ends; a pulse with no note expects length zero.
  always @(negedge mclk_i) begin
    if (tile_rst_o === 1'b1) run++;
    else if (run != 0) begin
      lv = (len_q.size() == 0) ? 0 : len_q.pop_front();
      `CHK("tile_rst_len", lv, run)
      run = 0;
    end
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin n_mismatch++; print_verdict; end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    #2 rst_n_i = 1;
    repeat (4) @(posedge mclk_i);
    #2 rd(8'h00, 8'h01);
    rd(8'h01, 8'h01);
    rd(8'h02, 8'h03);
    rd(8'h03, 8'h00);
    `CHK("src_sel", 1'b1, src_sel_o)
    `CHK("xclk_run", 1'b1, n_xedge > 0)
    $display("reset values done");
    acc(8'h04, 8'h00, 8'hFF, 1'b1);
    rd(8'h00, 8'h03);
    len_q.push_back(4);
    acc(8'h04, 8'h00, 8'h02, 1'b1);
    `CHK("src_sel", 1'b0, src_sel_o)
    acc(8'h04, 8'h01, 8'hFE, 1'b1);
    rd(8'h01, 8'h02);
    `CHK("int_en", 1'b0, int_osc_en_o)
    `CHK("int_slow", 1'b1, int_osc_slow_o)
    acc(8'h04, 8'h02, 8'hFD, 1'b1);
    rd(8'h02, 8'h01);
    `CHK("bias", 1'b0, xtal_bias_en_o)
    $display("register writes done");
    repeat (8) begin
      p = 8'($random(seed));
      if (p == 8'h04) p = 8'h05;
      acc(p, 8'h01, 8'($random(seed)), 1'b1);
      acc(p, 8'h01, 8'h00, 1'b0);
    end
    rd(8'h01, 8'h02);
    $display("foreign peripheral done");
    acc(8'h04, 8'h01, 8'h01, 1'b1);
    // The enable is still set, so going back to the on-chip source pulses the tile reset too.
    len_q.push_back(4);
    acc(8'h04, 8'h00, 8'h03, 1'b1);
    acc(8'h04, 8'h02, 8'h00, 1'b1);
    rd(8'h02, 8'h00);
    `CHK("xtal_en", 1'b0, xtal_en_o)
    k = n_xedge;
    repeat (10) @(posedge mclk_i);
    `CHK("xclk_stop", k, n_xedge)
    `CHK("rst_pulses_left", 0, len_q.size())
    $display("source swap done");
    print_verdict;
  end
endmodule
